// *** bg_bus_glue.sv ***
// processor board glue: memory gating, bit bus, interrupt encoder, reset stretch
`timescale 1ns/100ps
`default_nettype none
`include "bg_params.svh"
module bg_bus_glue
#(
	parameter int RST_HOLD_CYCLES = `BG_RST_HOLD
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire bg_pkg::bg_apb_req_t apbReq,
	output bg_pkg::bg_apb_rsp_t apbRsp,
	output logic irq,
	input wire bg_pkg::bg_cpu_bus_t cpuBus,
	input wire logic [15:0] cpuDataIn,
	output logic [15:0] cpuDataOut,
	output logic cpuDataOe,
	output bg_pkg::bg_mem_ctl_t memCtl,
	output logic [15:0] memWdata,
	input wire logic [15:0] memRdata,
	input wire logic bitIoClock,
	input wire logic bitIoDataOut,
	output logic bitIoDataIn,
	input wire logic [14:0] userInputs,
	input wire logic termRxd,
	output logic [15:0] bitOutputs,
	output logic termTxd,
	output logic progEnable,
	input wire logic [7:0] irqLines,
	output logic interruptRequestN,
	output logic [3:0] irqLevelCode,
	input wire logic manualResetN,
	output logic cpuResetN
);
	import bg_pkg::*;

	// whole block state; one register and its next value
	bg_state_t s;
	bg_state_t n;
	// helpers rebuilt from scratch every cycle
	logic [15:0] inBits;
	logic bitHit;
	logic bitStrobe;
	logic [3:0] bitIdx;
	logic [7:0] pend;
	logic [2:0] ev;
	logic [2:0] clr;
	logic apbAccess;
	logic rstTrigger;
	logic [31:0] rdVal;
	logic rdErr;
	logic [4:0] regHit;

	// level 0 wins; codes start at 1 so that code 0 never reads as a request
	function automatic logic [3:0] encodeLevel(input logic [7:0] lv);
		logic [3:0] code;
		code = 4'h0;
		for (int i = `BG_IRQ_LEVELS - 1; i >= 0; i--)
		begin
			if (lv[i])
			begin
				code = 4'(i + 1);
			end
		end
		return code;
	endfunction

	// plain scan rather than a shift, so the result is one bit by construction
	function automatic logic bitMux(input logic [15:0] v, input logic [3:0] k);
		logic b;
		b = 1'b0;
		for (int i = 0; i < `BG_BITIO_BITS; i++)
		begin
			if (k == 4'(i))
			begin
				b = v[i];
			end
		end
		return b;
	endfunction

	// one-hot register select, shared by the read mux and the write decode
	function automatic logic [4:0] regSelect(input logic [7:0] a);
		logic [4:0] sel;
		sel = 5'h00;
		if (a == `BG_OFS_CTRL)
		begin
			sel[0] = 1'b1;
		end
		else if (a == `BG_OFS_BITS)
		begin
			sel[1] = 1'b1;
		end
		else if (a == `BG_OFS_ISTAT)
		begin
			sel[2] = 1'b1;
		end
		else if (a == `BG_OFS_IMASK)
		begin
			sel[3] = 1'b1;
		end
		else if (a == `BG_OFS_IRQV)
		begin
			sel[4] = 1'b1;
		end
		return sel;
	endfunction

	always_comb
	begin
		n = s;
		ev = 3'h0;
		clr = 3'h0;
		rdVal = 32'h0000_0000;
		rdErr = 1'b0;

		// memory path only under a low strobe; the byte select never arrives here
		n.mem.addr = cpuBus.wordAddr;
		n.mem.select = !cpuBus.memoryAccessStrobeN;
		n.mem.outputEnable = !cpuBus.memoryAccessStrobeN && cpuBus.dataBusInputDir;
		// a write also needs the processor's own write strobe
		n.mem.writeEnable = !cpuBus.memoryAccessStrobeN && !cpuBus.dataBusInputDir
			&& !cpuBus.writeEnableN;
		n.memWdata = cpuDataIn;
		// memory answers a cycle after select, so read data trails the strobe
		n.cpuDataOut = memRdata;
		n.cpuDataOe = n.mem.outputEnable;

		// bit bus: control codes share the address lines but decode to nothing
		inBits = {userInputs, termRxd};
		bitIdx = cpuBus.wordAddr[3:0];
		bitHit = cpuBus.memoryAccessStrobeN
			&& (cpuBus.wordAddr[11:4] == `BG_BITIO_BASE);
		// edge against last cycle's clock; a clock held high writes only once
		n.bitClkPrev = bitIoClock;
		bitStrobe = bitIoClock && !s.bitClkPrev && bitHit;
		if (bitStrobe)
		begin
			n.outLatch[bitIdx] = bitIoDataOut;
			ev[`BG_EV_BITWR] = 1'b1;
		end
		// a miss reads as zero, never a stale bit
		n.bitIoDataIn = bitHit && bitMux(inBits, bitIdx);

		// interrupt levels pass two flops before reaching the encoder
		n.irqSync1 = irqLines;
		n.irqSync2 = s.irqSync1;
		pend = s.ctrl[`BG_CTRL_IRQEN] ? s.irqSync2 : 8'h00;
		// request and code leave one flop together, so they never show a mix
		n.interruptRequestN = !(|pend);
		n.irqLevelCode = encodeLevel(pend);
		// event on the step into request only, not while it is held
		if (!n.interruptRequestN && s.interruptRequestN)
		begin
			ev[`BG_EV_INTERRUPT_REQUEST_N] = 1'b1;
		end

		// register bus; one wait state so every answer comes from a flop
		apbAccess = apbReq.psel && apbReq.penable && !s.apbRsp.pready;
		n.apbRsp.pready = apbAccess;
		n.apbRsp.pslverr = 1'b0;
		regHit = regSelect(apbReq.paddr);
		if (regHit[0])
		begin
			rdVal = {30'h0, s.ctrl};
		end
		else if (regHit[1])
		begin
			rdVal = {inBits, s.outLatch};
		end
		else if (regHit[2])
		begin
			rdVal = {29'h0, s.intStat};
		end
		else if (regHit[3])
		begin
			rdVal = {29'h0, s.intMask};
		end
		else if (regHit[4])
		begin
			rdVal = {20'h0, s.irqLevelCode, s.irqSync2};
		end
		else
		begin
			rdErr = 1'b1;
		end
		// error stands only for the single cycle of pready; read data holds until the next access
		if (apbAccess)
		begin
			n.apbRsp.pslverr = rdErr;
			// read data is zero on writes
			n.apbRsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rdVal;
		end
		// the bit and level views are read-only; writes there are dropped
		// writes take effect at the edge that drops pready, one edge after the one that shows it
		if (apbReq.psel && apbReq.penable && s.apbRsp.pready && apbReq.pwrite)
		begin
			if (regHit[0])
			begin
				n.ctrl = apbReq.pwdata[1:0];
			end
			else if (regHit[2])
			begin
				clr = apbReq.pwdata[2:0];
			end
			else if (regHit[3])
			begin
				n.intMask = apbReq.pwdata[2:0];
			end
		end
		// soft reset bit is a one-shot; it clears itself once taken
		if (s.ctrl[`BG_CTRL_SOFTRST])
		begin
			n.ctrl[`BG_CTRL_SOFTRST] = 1'b0;
		end

		// processor reset stretcher; a held switch keeps the count at zero
		n.manSync1 = manualResetN;
		n.manSync2 = s.manSync1;
		rstTrigger = !s.manSync2 || s.ctrl[`BG_CTRL_SOFTRST];
		case (s.rstState)
			BG_RS_HOLD:
			begin
				n.cpuResetN = 1'b0;
				// a trigger during hold restarts the count
				if (rstTrigger)
				begin
					n.rstCount = 4'h0;
				end
				else if (s.rstCount >= 4'(RST_HOLD_CYCLES - 1))
				begin
					n.rstState = BG_RS_RUN;
					n.cpuResetN = 1'b1;
					ev[`BG_EV_RSTDONE] = 1'b1;
				end
				else
				begin
					n.rstCount = s.rstCount + 4'h1;
				end
			end
			BG_RS_RUN:
			begin
				if (rstTrigger)
				begin
					n.rstState = BG_RS_HOLD;
					n.rstCount = 4'h0;
					n.cpuResetN = 1'b0;
				end
			end
			// any code off the one-hot pair falls back to hold
			default:
			begin
				n.rstState = BG_RS_HOLD;
				n.rstCount = 4'h0;
				n.cpuResetN = 1'b0;
			end
		endcase

		// a new event wins over a clear in the same cycle
		n.intStat = (s.intStat & ~clr) | ev;
		n.irq = |(n.intStat & s.intMask);
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			// encoder on, request idle high, processor held in reset
			s <= '0;
			s.ctrl <= `BG_CTRL_RST;
			s.bitClkPrev <= 1'b1;
			s.interruptRequestN <= 1'b1;
			s.manSync1 <= 1'b1;
			s.manSync2 <= 1'b1;
			s.rstState <= BG_RS_HOLD;
			s.cpuResetN <= 1'b0;
		end
		else
		begin
			s <= n;
		end
	end

	// every output is a flop of the state struct
	assign apbRsp = s.apbRsp;
	assign irq = s.irq;
	assign memCtl = s.mem;
	assign memWdata = s.memWdata;
	assign cpuDataOut = s.cpuDataOut;
	assign cpuDataOe = s.cpuDataOe;
	assign bitIoDataIn = s.bitIoDataIn;
	assign bitOutputs = s.outLatch;
	assign termTxd = s.outLatch[`BG_OUT_TERM];
	assign progEnable = s.outLatch[`BG_OUT_PROG];
	assign interruptRequestN = s.interruptRequestN;
	assign irqLevelCode = s.irqLevelCode;
	assign cpuResetN = s.cpuResetN;
endmodule
`default_nettype wire

// *** bg_params.svh ***
// constants for the processor board bus glue
`ifndef BG_PARAMS_SVH
`define BG_PARAMS_SVH
`define BG_OFS_CTRL 8'h00
`define BG_OFS_BITS 8'h04
`define BG_OFS_ISTAT 8'h08
`define BG_OFS_IMASK 8'h0C
`define BG_OFS_IRQV 8'h10
`define BG_CTRL_RST 2'h1
`define BG_CTRL_IRQEN 0
`define BG_CTRL_SOFTRST 1
`define BG_EV_BITWR 0
`define BG_EV_INTERRUPT_REQUEST_N 1
`define BG_EV_RSTDONE 2
`define BG_NUM_EV 3
`define BG_BITIO_BASE 8'h00
`define BG_BITIO_BITS 16
`define BG_IRQ_LEVELS 8
`define BG_RST_HOLD 3
`define BG_OUT_TERM 0
`define BG_OUT_PROG 1
`endif

// *** bg_pkg.sv ***
// types shared by the processor board bus glue
package bg_pkg;
	typedef enum logic [1:0]
	{
		BG_RS_HOLD = 2'b01,
		BG_RS_RUN = 2'b10
	} bg_rst_state_t;
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} bg_apb_req_t;
	typedef struct packed
	{
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} bg_apb_rsp_t;
	typedef struct packed
	{
		logic [14:0] wordAddr;
		logic memoryAccessStrobeN;
		logic dataBusInputDir;
		logic writeEnableN;
	} bg_cpu_bus_t;
	typedef struct packed
	{
		logic [14:0] addr;
		logic select;
		logic outputEnable;
		logic writeEnable;
	} bg_mem_ctl_t;
	typedef struct packed
	{
		bg_apb_rsp_t apbRsp;
		logic [1:0] ctrl;
		logic [2:0] intStat;
		logic [2:0] intMask;
		logic irq;
		bg_mem_ctl_t mem;
		logic [15:0] memWdata;
		logic [15:0] cpuDataOut;
		logic cpuDataOe;
		logic bitClkPrev;
		logic [15:0] outLatch;
		logic bitIoDataIn;
		logic [7:0] irqSync1;
		logic [7:0] irqSync2;
		logic interruptRequestN;
		logic [3:0] irqLevelCode;
		logic manSync1;
		logic manSync2;
		bg_rst_state_t rstState;
		logic [3:0] rstCount;
		logic cpuResetN;
	} bg_state_t;
endpackage

// *** bg_bus_glue_assertions.sv ***
// checker for the processor board bus glue
`timescale 1ns/100ps
`default_nettype none
module bg_bus_glue_assertions
#(
	parameter int RST_HOLD_CYCLES = 3
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire bg_pkg::bg_cpu_bus_t cpuBus,
	input wire bg_pkg::bg_mem_ctl_t memCtl,
	input wire logic cpuDataOe,
	input wire logic bitIoClock,
	input wire logic bitIoDataOut,
	input wire logic bitIoDataIn,
	input wire logic [14:0] userInputs,
	input wire logic termRxd,
	input wire logic [15:0] bitOutputs,
	input wire logic [7:0] irqLines,
	input wire logic interruptRequestN,
	input wire logic [3:0] irqLevelCode,
	input wire logic cpuResetN
);
	import bg_pkg::*;
	wire logic stb = cpuBus.memoryAccessStrobeN;
	wire logic hit = stb && cpuBus.wordAddr[11:4] == 8'h00;
	wire logic [15:0] inBits = {userInputs, termRxd};
	// line 0 wins, so scan from the lowest priority upward
	function automatic logic [3:0] enc(input logic [7:0] l);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 7; i >= 0; i--)
			if (l[i])
				c = 4'(i + 1);
		return c;
	endfunction
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_mem_gate: assert property (stb |=> !memCtl.select) else $error("memory selected without strobe");
	a_mem_addr: assert property (!stb |=> memCtl.select && memCtl.addr == $past(cpuBus.wordAddr))
		else $error("memory address wrong");
	a_data_dir: assert property (!cpuBus.dataBusInputDir |=> !cpuDataOe && !memCtl.outputEnable)
		else $error("data bus turned without input direction");
	a_bit_latch: assert property ($rose(bitIoClock) && hit |=>
		bitOutputs[$past(cpuBus.wordAddr[3:0])] == $past(bitIoDataOut)) else $error("output bit not latched");
	a_bit_guard: assert property ($rose(bitIoClock) && !hit |=> $stable(bitOutputs)) else $error("miss wrote");
	a_bit_input: assert property (hit |=> bitIoDataIn == $past(inBits[cpuBus.wordAddr[3:0]]))
		else $error("input bit wrong");
	a_irq_req: assert property (interruptRequestN == ($past(irqLines, 3) == 8'h00))
		else $error("request timing wrong");
	a_irq_code: assert property (!interruptRequestN |-> irqLevelCode == enc($past(irqLines, 3)))
		else $error("level code wrong");
	a_rst_hold: assert property ($rose(cpuResetN) |-> !$past(cpuResetN, 2) && !$past(cpuResetN, 3))
		else $error("processor reset too short");
	cover property ($rose(bitIoClock) && hit);
	cover property (!interruptRequestN && irqLevelCode == 4'h8);
	cover property ($rose(cpuResetN));
endmodule
bind bg_bus_glue bg_bus_glue_assertions #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) i_bg_bus_glue_assertions
	(.mclk, .rst_b, .cpuBus, .memCtl, .cpuDataOe, .bitIoClock, .bitIoDataOut, .bitIoDataIn, .userInputs,
	.termRxd, .bitOutputs, .irqLines, .interruptRequestN, .irqLevelCode, .cpuResetN);
`default_nettype wire

// *** bg_cpu_model.sv ***
// processor-side model: memory cycles and bit bus strobes
`timescale 1ns/100ps
`default_nettype none
module bg_cpu_model
(
	input wire logic mclk,
	output bg_pkg::bg_cpu_bus_t cpuBus,
	output logic [15:0] cpuDataIn,
	output logic bitIoClock,
	output logic bitIoDataOut
);
	import bg_pkg::*;
	initial
	begin
		cpuBus = '{15'h0000, 1'b1, 1'b0, 1'b1};
		cpuDataIn = 16'h0000;
		bitIoClock = 1'b0;
		bitIoDataOut = 1'b0;
	end
	task automatic memCycle(input logic [14:0] a, input logic rd, input logic [15:0] d);
		@(posedge mclk);
		cpuBus <= '{a, 1'b0, rd, rd};
		cpuDataIn <= d;
		repeat (2) @(posedge mclk);
		cpuBus <= '{a, 1'b1, 1'b0, 1'b1};
		cpuDataIn <= ~d;
	endtask
	// clk low only sets the address, as for an input test
	task automatic bitCycle(input logic [14:0] a, input logic d, input logic clk);
		@(posedge mclk);
		cpuBus <= '{a, 1'b1, 1'b0, 1'b1};
		bitIoDataOut <= d;
		@(posedge mclk);
		bitIoClock <= clk;
		@(posedge mclk);
		bitIoClock <= 1'b0;
		bitIoDataOut <= ~d;
	endtask
endmodule
`default_nettype wire

// *** bg_bus_glue_tb_top.sv ***
// self-checking bench for the processor board bus glue
`timescale 1ns/100ps
`default_nettype none
module bg_bus_glue_tb_top;
	import bg_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	bg_apb_req_t apbReq = '0;
	bg_apb_rsp_t apbRsp;
	bg_cpu_bus_t cpuBus;
	bg_mem_ctl_t memCtl;
	logic [15:0] cpuDataIn;
	logic [15:0] memRdata;
	logic [15:0] bitOutputs;
	logic [15:0] cpuDataOut;
	logic [15:0] memWdata;
	logic cpuDataOe;
	logic termTxd;
	logic progEnable;
	logic [14:0] userInputs = 15'h0000;
	logic termRxd = 1'b0;
	logic [7:0] irqLines = 8'h00;
	logic manualResetN = 1'b1;
	logic bitIoClock, bitIoDataOut, bitIoDataIn, irq, interruptRequestN, cpuResetN;
	logic [3:0] irqLevelCode;
	logic [31:0] rdata;
	logic rerr;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	always #20 mclk = ~mclk;
	// memory answers only while enabled, else the released bus floats high
	assign memRdata = memCtl.outputEnable ? {1'b0, memCtl.addr} : 16'hFFFF;
	bg_bus_glue #(.RST_HOLD_CYCLES(3)) i_bg_bus_glue (.mclk(mclk), .rst_b(rst_b), .apbReq(apbReq),
		.apbRsp(apbRsp), .irq(irq), .cpuBus(cpuBus), .cpuDataIn(cpuDataIn), .cpuDataOut(cpuDataOut),
		.cpuDataOe(cpuDataOe), .memCtl(memCtl), .memWdata(memWdata), .memRdata(memRdata),
		.bitIoClock(bitIoClock), .bitIoDataOut(bitIoDataOut),
		.bitIoDataIn(bitIoDataIn), .userInputs(userInputs), .termRxd(termRxd), .bitOutputs(bitOutputs),
		.termTxd(termTxd), .progEnable(progEnable), .irqLines(irqLines), .interruptRequestN(interruptRequestN),
		.irqLevelCode(irqLevelCode), .manualResetN(manualResetN), .cpuResetN(cpuResetN));
	bg_cpu_model i_bg_cpu_model (.mclk(mclk), .cpuBus(cpuBus), .cpuDataIn(cpuDataIn), .bitIoClock(bitIoClock),
		.bitIoDataOut(bitIoDataOut));
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		apbReq <= '{1'b1, 1'b0, w, a, wd};
		@(posedge mclk);
		apbReq.penable <= 1'b1;
		do
			@(posedge mclk);
		while (apbRsp.pready !== 1'b1);
		rdata = apbRsp.prdata;
		rerr = apbRsp.pslverr;
		apbReq <= '0;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			conclude();
		end
	end
	initial
	begin
		logic [7:0] lv [4];
		logic [3:0] cd [4];
		int k;
		lv = '{8'h80, 8'h81, 8'h0C, 8'h00};
		cd = '{4'h8, 4'h1, 4'h3, 4'h0};
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		k = 0;
		while (cpuResetN !== 1'b1 && k < 20)
		begin
			@(posedge mclk);
			k++;
		end
		chk(32'(k >= 3 && k < 20), 32'h1);
		$display("test reset done");
		apb(1'b0, 8'h00, 32'h0);
		chk(rdata, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk(32'(rerr), 32'h1);
		apb(1'b1, 8'h0C, 32'h1);
		for (int i = 0; i < 16; i++)
			i_bg_cpu_model.bitCycle(15'(i), 1'((16'hA5C3 >> i) & 16'h1), 1'b1);
		@(posedge mclk);
		chk(32'(bitOutputs), 32'hA5C3);
		chk(32'({progEnable, termTxd}), 32'h3);
		i_bg_cpu_model.bitCycle(15'h0012, 1'b0, 1'b1);
		i_bg_cpu_model.memCycle(15'h0003, 1'b0, 16'h1234);
		chk(32'({memCtl.addr, memCtl.select, memCtl.writeEnable, memCtl.outputEnable, cpuDataOe}), 32'h0000_003C);
		chk(32'(memWdata), 32'h1234);
		@(posedge mclk);
		chk(32'(bitOutputs), 32'hA5C3);
		apb(1'b0, 8'h08, 32'h0);
		chk(32'(rdata[0] & irq), 32'h1);
		apb(1'b1, 8'h08, 32'h7);
		apb(1'b1, 8'h0C, 32'h0);
		i_bg_cpu_model.bitCycle(15'h0000, 1'b0, 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		chk(32'({rdata[0], irq}), 32'h2);
		$display("test bit outputs done");
		@(posedge mclk);
		{userInputs, termRxd} <= 16'h3C5A;
		for (int i = 0; i < 16; i++)
		begin
			i_bg_cpu_model.bitCycle(15'(i), 1'b0, 1'b0);
			chk(32'(bitIoDataIn), 32'((16'h3C5A >> i) & 16'h1));
		end
		i_bg_cpu_model.memCycle(15'h7ABC, 1'b1, 16'h0000);
		chk(32'({memCtl.addr, memCtl.select, memCtl.writeEnable, memCtl.outputEnable, cpuDataOe}), 32'h0007_ABCB);
		@(posedge mclk);
		chk(32'(cpuDataOut), 32'h7ABC);
		$display("test bit inputs done");
		for (int j = 0; j < 4; j++)
		begin
			@(posedge mclk);
			irqLines <= lv[j];
			repeat (5) @(posedge mclk);
			chk(32'(interruptRequestN), 32'(lv[j] == 8'h00));
			if (lv[j] != 8'h00)
				chk(32'(irqLevelCode), 32'(cd[j]));
		end
		$display("test interrupts done");
		apb(1'b1, 8'h00, 32'h3);
		repeat (2) @(posedge mclk);
		chk(32'(cpuResetN), 32'h0);
		k = 0;
		while (cpuResetN !== 1'b1 && k < 20)
		begin
			@(posedge mclk);
			k++;
		end
		chk(32'(k >= 3 && k < 20), 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk(rdata, 32'h1);
		$display("test soft reset done");
		conclude();
	end
endmodule
`default_nettype wire
